// ===== hw/buck_pkg.sv
// Constants and types for the buck channel fault and hiccup controller.
// Assumes one switching-cycle tick per cycle, synchronous to mclk.
package buck_pkg;

    localparam int          OVL_LIMIT       = 512;
    localparam int          OVL_CNT_W       = 10;
    localparam int          HICCUP_CYCLES   = 16384;
    localparam int          HICCUP_W        = 15;

    localparam logic [3:0]  ADDR_CTRL       = 4'h0;
    localparam logic [3:0]  ADDR_STATUS     = 4'h1;
    localparam logic [3:0]  ADDR_MASK       = 4'h2;
    localparam logic [3:0]  ADDR_STATE      = 4'h3;
    localparam logic [3:0]  ADDR_OVL_CNT    = 4'h4;

    localparam logic [7:0]  CTRL_RST        = 8'h01;
    localparam logic [7:0]  MASK_RST        = 8'h00;
    localparam int          CTRL_RUN_BIT    = 0;

    localparam int          EV_PEAK         = 0;
    localparam int          EV_SOURCE       = 1;
    localparam int          EV_SINK         = 2;
    localparam int          EV_OVL          = 3;
    localparam int          EV_THERM        = 4;
    localparam int          EV_RESTART      = 5;
    localparam int          EV_W            = 6;

    localparam int          STATE_PH_LSB    = 4;

    typedef enum logic [2:0] {
        ST_POWERUP    = 3'b000,
        ST_RUN        = 3'b001,
        ST_OVL_HICCUP = 3'b010,
        ST_THERM_STOP = 3'b011,
        ST_THERM_WAIT = 3'b100
    } mode_t;

    typedef enum logic [1:0] {
        PH_HS  = 2'b00,
        PH_LS  = 2'b01,
        PH_OFF = 2'b10
    } phase_t;

endpackage

// ===== hw/cycle_timer.sv
// Switching-cycle counter used for both hiccup intervals.
// Assumes tick is a one-mclk pulse per switching cycle.
`timescale 1ns/1ps
module cycle_timer #(
    parameter int W = 15
) (
    input  wire logic         mclk,
    input  wire logic         rstn,
    input  wire logic         run,
    input  wire logic         tick,
    input  wire logic [W-1:0] limit,
    output logic              done
);

    typedef struct packed {
        logic [W-1:0] count;
    } timer_t;

    timer_t s_q;
    timer_t s_d;

    // The count restarts from zero whenever run drops.
    always_comb
    begin
        s_d = s_q;
        if (!run)
        begin
            s_d.count = '0;
        end
        else if (tick && (s_q.count != limit))
        begin
            s_d.count = s_q.count + {{(W-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign done = run && (s_q.count == limit);

endmodule

// ===== hw/buck_fault_hiccup_control.sv
// Cycle-by-cycle current limit, overload hiccup and thermal restart control for one buck channel.
// Assumes comparator flags and the cycle tick are synchronous to mclk; registers are on a plain port.
`timescale 1ns/1ps

// Functional notes
// - Peak current trip: high-side off, low-side on.
// - Source limit at cycle end holds low-side next.
// - High-side restarts only with source limit clear.
// - Sink limit: both switches off until next cycle.
// - Over 512 overload cycles stops all switching.
// - Overload hiccup: 16384 cycles off, then restart.
// - Over-temperature stops all switching.
// - Temperature release starts the thermal hiccup counter.
// - Thermal hiccup end re-runs full power-up.
module buck_fault_hiccup_control
    import buck_pkg::*;
#(
    parameter logic [HICCUP_W-1:0] HICCUP_LEN = HICCUP_W'(HICCUP_CYCLES)
) (
    input  wire logic       mclk,
    input  wire logic       rstn,
    input  wire logic       cycle_start,
    input  wire logic       peak_trip,
    input  wire logic       ls_source_lim,
    input  wire logic       ls_sink_lim,
    input  wire logic       overload,
    input  wire logic       over_temp,
    input  wire logic       softstart_done,
    input  wire logic [3:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    output logic            hs_en,
    output logic            ls_en,
    output logic            softstart_run,
    output logic            irq
);

    typedef struct packed {
        mode_t                mode;
        phase_t               phase;
        logic                 hs;
        logic                 ls;
        logic                 ss;
        logic [OVL_CNT_W-1:0] ovl_cnt;
        logic [7:0]           ctrl;
        logic [7:0]           mask;
        logic [EV_W-1:0]      status;
        logic [7:0]           rdata;
    } state_t;

    state_t s_q;
    state_t s_d;

    logic   timer_run;
    logic   timer_done;

    assign timer_run = (s_q.mode == ST_OVL_HICCUP) || (s_q.mode == ST_THERM_WAIT);

    cycle_timer #(
        .W     (HICCUP_W)
    ) u_hiccup (
        .mclk  (mclk),
        .rstn  (rstn),
        .run   (timer_run),
        .tick  (cycle_start),
        .limit (HICCUP_LEN),
        .done  (timer_done)
    );

    always_comb
    begin
        logic [EV_W-1:0] ev;
        logic            sw_ok;
        logic            rd_status;
        ev        = '0;
        sw_ok     = 1'b0;
        rd_status = 1'b0;
        s_d       = s_q;

        // Operating mode sequencing; thermal stop overrides every other mode.
        if (over_temp && (s_q.mode != ST_THERM_STOP) && (s_q.mode != ST_THERM_WAIT))
        begin
            s_d.mode        = ST_THERM_STOP;
            s_d.ovl_cnt     = '0;
            ev[EV_THERM]    = 1'b1;
        end
        else
        begin
            case (s_q.mode)
                ST_POWERUP:
                begin
                    if (softstart_done)
                    begin
                        s_d.mode       = ST_RUN;
                        ev[EV_RESTART] = 1'b1;
                    end
                end
                ST_RUN:
                begin
                    if (cycle_start)
                    begin
                        if (!overload)
                        begin
                            s_d.ovl_cnt = '0;
                        end
                        else if (s_q.ovl_cnt == OVL_CNT_W'(OVL_LIMIT))
                        begin
                            s_d.mode    = ST_OVL_HICCUP;
                            s_d.ovl_cnt = '0;
                            ev[EV_OVL]  = 1'b1;
                        end
                        else
                        begin
                            s_d.ovl_cnt = s_q.ovl_cnt + {{(OVL_CNT_W-1){1'b0}}, 1'b1};
                        end
                    end
                end
                ST_OVL_HICCUP:
                begin
                    if (timer_done)
                    begin
                        s_d.mode       = ST_RUN;
                        ev[EV_RESTART] = 1'b1;
                    end
                end
                ST_THERM_STOP:
                begin
                    if (!over_temp)
                    begin
                        s_d.mode = ST_THERM_WAIT;
                    end
                end
                ST_THERM_WAIT:
                begin
                    if (over_temp)
                    begin
                        s_d.mode = ST_THERM_STOP;
                    end
                    else if (timer_done)
                    begin
                        s_d.mode = ST_POWERUP;
                    end
                end
                default:
                begin
                    s_d.mode = ST_POWERUP;
                end
            endcase
        end

        sw_ok = s_q.ctrl[CTRL_RUN_BIT] && ((s_d.mode == ST_RUN) || (s_d.mode == ST_POWERUP));

        // Switch phase within a switching cycle; a new cycle takes precedence over trips.
        if (!sw_ok)
        begin
            s_d.phase = PH_OFF;
        end
        else if (cycle_start)
        begin
            if (ls_source_lim)
            begin
                s_d.phase     = PH_LS;
                ev[EV_SOURCE] = 1'b1;
            end
            else
            begin
                s_d.phase = PH_HS;
            end
        end
        else if ((s_q.phase == PH_HS) && peak_trip)
        begin
            s_d.phase   = PH_LS;
            ev[EV_PEAK] = 1'b1;
        end
        else if ((s_q.phase == PH_LS) && ls_sink_lim)
        begin
            s_d.phase   = PH_OFF;
            ev[EV_SINK] = 1'b1;
        end

        s_d.hs = (s_d.phase == PH_HS);
        s_d.ls = (s_d.phase == PH_LS);
        s_d.ss = (s_d.mode == ST_POWERUP);

        // Register port: writes, read data for one cycle, read-clear of status.
        s_d.rdata = 8'h00;
        if (reg_wr)
        begin
            if (reg_addr == ADDR_CTRL)
            begin
                s_d.ctrl = reg_wdata;
            end
            else if (reg_addr == ADDR_MASK)
            begin
                s_d.mask = reg_wdata;
            end
        end
        if (reg_rd)
        begin
            if (reg_addr == ADDR_CTRL)
            begin
                s_d.rdata = s_q.ctrl;
            end
            else if (reg_addr == ADDR_STATUS)
            begin
                s_d.rdata = {{(8-EV_W){1'b0}}, s_q.status};
                rd_status = 1'b1;
            end
            else if (reg_addr == ADDR_MASK)
            begin
                s_d.rdata = s_q.mask;
            end
            else if (reg_addr == ADDR_STATE)
            begin
                s_d.rdata = {2'b00, s_q.phase, 1'b0, s_q.mode};
            end
            else if (reg_addr == ADDR_OVL_CNT)
            begin
                s_d.rdata = s_q.ovl_cnt[OVL_CNT_W-1:2];
            end
        end

        // An event in the same cycle as the clearing read stays set.
        s_d.status = (rd_status ? {EV_W{1'b0}} : s_q.status) | ev;
    end

    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            s_q.mode    <= ST_POWERUP;
            s_q.phase   <= PH_OFF;
            s_q.hs      <= 1'b0;
            s_q.ls      <= 1'b0;
            s_q.ss      <= 1'b0;
            s_q.ovl_cnt <= '0;
            s_q.ctrl    <= CTRL_RST;
            s_q.mask    <= MASK_RST;
            s_q.status  <= '0;
            s_q.rdata   <= 8'h00;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign hs_en         = s_q.hs;
    assign ls_en         = s_q.ls;
    assign softstart_run = s_q.ss;
    assign reg_rdata     = s_q.rdata;
    assign irq           = |(s_q.status & s_q.mask[EV_W-1:0]);

endmodule

// ===== tb/buck_stage_model.sv
// Power stage stand-in: the peak current comparator trips after a set high-side on time.
// Fed by the high-side gate enable of the controller.
`timescale 1ns/1ps
module buck_stage_model #(
    parameter int TRIP = 3
) (
    input  wire logic mclk,
    input  wire logic hs_en,
    output logic      peak_trip
);
    int on_q = 0;

    // Inductor current ramps only while the high-side switch conducts.
    always_ff @(posedge mclk)
    begin
        on_q <= hs_en ? on_q + 1 : 0;
    end

    assign peak_trip = hs_en && (on_q >= TRIP);
endmodule

// ===== tb/buck_fault_hiccup_control_asserts.sv
// Checker of the gate and soft start outputs of the buck controller.
// Sees only the top module ports; bound below.
`timescale 1ns/1ps
module buck_ctl_chk (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic cycle_start,
    input wire logic peak_trip,
    input wire logic ls_source_lim,
    input wire logic ls_sink_lim,
    input wire logic over_temp,
    input wire logic softstart_done,
    input wire logic hs_en,
    input wire logic ls_en,
    input wire logic softstart_run
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!rstn);

    property p_peak;
        hs_en && peak_trip && !cycle_start && !over_temp |=> !hs_en && ls_en;
    endproperty
    a_peak: assert property (p_peak) else $error("peak trip not handed to low side");
    property p_src;
        cycle_start && ls_source_lim |=> !hs_en;
    endproperty
    a_src: assert property (p_src) else $error("high side on under source limit");
    property p_hs_on;
        $rose(hs_en) |-> $past(cycle_start) && !$past(ls_source_lim);
    endproperty
    a_hs_on: assert property (p_hs_on) else $error("high side on outside a clear cycle start");
    property p_sink;
        ls_en && ls_sink_lim && !cycle_start |=> !ls_en && !hs_en;
    endproperty
    a_sink: assert property (p_sink) else $error("sink limit left a gate on");
    property p_ls_on;
        $rose(ls_en) |-> $past(hs_en) || $past(cycle_start);
    endproperty
    a_ls_on: assert property (p_ls_on) else $error("low side on from idle mid cycle");
    property p_hot;
        over_temp |=> !hs_en && !ls_en;
    endproperty
    a_hot: assert property (p_hot) else $error("switching while over temperature");
    property p_hot_ss;
        over_temp |=> !softstart_run;
    endproperty
    a_hot_ss: assert property (p_hot_ss) else $error("soft start while over temperature");
    property p_ss_end;
        softstart_run && softstart_done && !over_temp |=> !softstart_run;
    endproperty
    a_ss_end: assert property (p_ss_end) else $error("soft start did not end");
endmodule

bind buck_fault_hiccup_control buck_ctl_chk buck_ctl_chk_inst (
    .mclk           (mclk),
    .rstn           (rstn),
    .cycle_start    (cycle_start),
    .peak_trip      (peak_trip),
    .ls_source_lim  (ls_source_lim),
    .ls_sink_lim    (ls_sink_lim),
    .over_temp      (over_temp),
    .softstart_done (softstart_done),
    .hs_en          (hs_en),
    .ls_en          (ls_en),
    .softstart_run  (softstart_run)
);

// ===== tb/tb_buck_fault_hiccup_control.sv
// Self-checking bench for the buck fault and hiccup controller.
// The bench times switching cycles; a stage model closes the peak current loop.
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin mismatches++; $display("[FAIL] t=%0t %h %h", $time, a, e); end end
module tb_buck_fault_hiccup_control;
    import buck_pkg::*;
    localparam int P = 10;
    logic       mclk = 1'b0, rstn = 1'b0, cycle_start = 1'b0, ls_source_lim = 1'b0, ls_sink_lim = 1'b0;
    logic       overload = 1'b0, over_temp = 1'b0, softstart_done = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic       peak_trip, hs_en, ls_en, softstart_run, irq, hs_seen, ls_seen;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00, reg_rdata;
    int         mismatches = 0, n_checks = 0, cyc_n = 0;

    always #20 mclk = ~mclk;

    buck_fault_hiccup_control #(
        .HICCUP_LEN     (15'h0004)
    ) buck_fault_hiccup_control_inst (
        .mclk           (mclk),
        .rstn           (rstn),
        .cycle_start    (cycle_start),
        .peak_trip      (peak_trip),
        .ls_source_lim  (ls_source_lim),
        .ls_sink_lim    (ls_sink_lim),
        .overload       (overload),
        .over_temp      (over_temp),
        .softstart_done (softstart_done),
        .reg_addr       (reg_addr),
        .reg_wdata      (reg_wdata),
        .reg_wr         (reg_wr),
        .reg_rd         (reg_rd),
        .reg_rdata      (reg_rdata),
        .hs_en          (hs_en),
        .ls_en          (ls_en),
        .softstart_run  (softstart_run),
        .irq            (irq)
    );
    buck_stage_model buck_stage_model_inst (.mclk(mclk), .hs_en(hs_en), .peak_trip(peak_trip));

    task automatic give_verdict();
        if (mismatches == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(posedge mclk);
        `CHK(reg_rdata & m, e)
    endtask

    // Runs n switching cycles and notes whether each gate was on at any time.
    task automatic cyc(input int n);
        hs_seen = 1'b0;
        ls_seen = 1'b0;
        repeat (n)
        begin
            cycle_start <= 1'b1;
            @(posedge mclk);
            cycle_start <= 1'b0;
            repeat (P - 1)
            begin
                @(posedge mclk);
                hs_seen |= hs_en;
                ls_seen |= ls_en;
            end
        end
    endtask

    always @(posedge mclk)
    begin
        cyc_n++;
        if (cyc_n == 20000)
        begin
            mismatches++;
            give_verdict();
        end
    end

    initial
    begin
        repeat (8) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        @(posedge mclk);
        `CHK(softstart_run, 1'b1)
        rd_chk(ADDR_CTRL, 8'hff, CTRL_RST);
        rd_chk(ADDR_MASK, 8'hff, MASK_RST);
        rd_chk(4'hf, 8'hff, 8'h00);
        cyc(1);
        `CHK(hs_seen & ls_seen, 1'b1)
        softstart_done <= 1'b1;
        @(posedge mclk);
        rd_chk(ADDR_STATE, 8'h07, 8'h01);
        rd_chk(ADDR_STATUS, 8'h21, 8'h21);
        wr(ADDR_MASK, 8'h01);
        `CHK(irq, 1'b0)
        cyc(1);
        `CHK(irq, 1'b1)
        rd_chk(ADDR_STATUS, 8'h01, 8'h01);
        `CHK(irq, 1'b0)
        wr(ADDR_MASK, 8'h00);
        ls_source_lim <= 1'b1;
        cyc(1);
        `CHK({hs_seen, ls_seen}, 2'b01)
        ls_source_lim <= 1'b0;
        cyc(1);
        `CHK(hs_seen, 1'b1)
        ls_sink_lim <= 1'b1;
        cyc(1);
        `CHK({hs_en, ls_en}, 2'b00)
        ls_sink_lim <= 1'b0;
        wr(ADDR_CTRL, 8'h00);
        cyc(1);
        `CHK(hs_seen, 1'b0)
        wr(ADDR_CTRL, CTRL_RST);
        overload <= 1'b1;
        cyc(511);
        overload <= 1'b0;
        cyc(1);
        rd_chk(ADDR_OVL_CNT, 8'hff, 8'h00);
        overload <= 1'b1;
        cyc(512);
        rd_chk(ADDR_OVL_CNT, 8'hff, 8'h80);
        rd_chk(ADDR_STATE, 8'h07, 8'h01);
        cyc(1);
        rd_chk(ADDR_STATE, 8'h07, 8'h02);
        overload <= 1'b0;
        cyc(3);
        `CHK(hs_seen | ls_seen, 1'b0)
        rd_chk(ADDR_STATE, 8'h07, 8'h02);
        cyc(2);
        rd_chk(ADDR_STATE, 8'h07, 8'h01);
        rd_chk(ADDR_STATUS, 8'h3e, 8'h2e);
        softstart_done <= 1'b0;
        over_temp <= 1'b1;
        cyc(3);
        `CHK(hs_seen | ls_seen, 1'b0)
        rd_chk(ADDR_STATE, 8'h07, 8'h03);
        over_temp <= 1'b0;
        cyc(3);
        rd_chk(ADDR_STATE, 8'h07, 8'h04);
        over_temp <= 1'b1;
        @(posedge mclk);
        @(posedge mclk);
        over_temp <= 1'b0;
        cyc(3);
        rd_chk(ADDR_STATE, 8'h07, 8'h04);
        cyc(2);
        rd_chk(ADDR_STATE, 8'h07, 8'h00);
        `CHK(softstart_run, 1'b1)
        rd_chk(ADDR_STATUS, 8'h10, 8'h10);
        give_verdict();
    end
endmodule
